//--- rtl/asq_pkg.sv
package asq_pkg;
    localparam int          NUM_SEQ        = 4;
    localparam int          SEL_W          = 4;
    localparam int          ADDR_W         = 12;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          SAMPLE_W       = 12;
    localparam int          PTR_W          = 3;
    // Register byte offsets
    localparam logic [11:0] OFF_RAW_STATUS = 12'h004;
    localparam logic [11:0] OFF_IRQ_GATE   = 12'h008;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h00c;
    localparam logic [11:0] OFF_FIFO_FULL  = 12'h010;
    localparam logic [11:0] OFF_TRIG_SEL   = 12'h014;
    // Read answer for an empty register slot
    localparam logic [31:0] RD_ZERO        = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    localparam logic [15:0] TRIG_RESET     = 16'h0000;
    // Trigger selector codes
    localparam logic [3:0]  TRIG_PROC      = 4'h0;
    localparam logic [3:0]  TRIG_COMP0     = 4'h1;
    localparam logic [3:0]  TRIG_PIN       = 4'h4;
    localparam logic [3:0]  TRIG_TIMER     = 4'h5;
    localparam logic [3:0]  TRIG_PWM0      = 4'h6;
    localparam logic [3:0]  TRIG_PWM1      = 4'h7;
    localparam logic [3:0]  TRIG_ALWAYS    = 4'hf;
    typedef enum logic [1:0] {
        ASQ_IDLE = 2'b00,
        ASQ_RESP = 2'b01
    } asq_bus_e;
endpackage

//--- rtl/asq_trig_if.sv
`timescale 1ns/1ps
`default_nettype none
interface asq_trig_if;
    import asq_pkg::*;
    logic [SEL_W-1:0] code;
    logic             comp0;
    logic             pin;
    logic             timer;
    logic             pwm0;
    logic             pwm1;
    logic             proc_go;
    logic             start;
    modport ctl (output code, comp0, pin, timer, pwm0, pwm1, proc_go, input start);
    modport sel (input code, comp0, pin, timer, pwm0, pwm1, proc_go, output start);
endinterface
`default_nettype wire

//--- rtl/asq_trig_sel.sv
`timescale 1ns/1ps
`default_nettype none
module asq_trig_sel
(
    input  wire logic core_clk,
    input  wire logic rst,
    asq_trig_if.sel   t
);
    import asq_pkg::*;
    typedef struct packed { logic start; } asq_sel_s;
    asq_sel_s st;
    asq_sel_s next_st;
    // -------------------------------------------------
    // Code table, one copy per sequencer
    // -------------------------------------------------
    always_comb
    begin
        next_st = st;
        case (t.code) // R9 R10
            TRIG_PROC:   next_st.start = t.proc_go;
            TRIG_COMP0:  next_st.start = t.comp0;
            TRIG_PIN:    next_st.start = t.pin;
            TRIG_TIMER:  next_st.start = t.timer;
            TRIG_PWM0:   next_st.start = t.pwm0;
            TRIG_PWM1:   next_st.start = t.pwm1;
            TRIG_ALWAYS: next_st.start = 1'b1;
            default:     next_st.start = 1'b0; // Reserved codes never start
        endcase
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end
    assign t.start = st.start;
endmodule
`default_nettype wire

//--- rtl/asq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Status read is raw flag AND gate
// R2: Writing one clears status and raw flag
// R3: Clear works even when gated bit zero
// R4: Gated status drives level interrupt line
// R5: Write into full FIFO sets overflow flag
// R6: Overflowing sample dropped, FIFO unchanged
// R7: Overflow flag stays until one written there
// R8: Four 4-bit selectors, bits 15:0
// R9: Selector code table, zero is processor
// R10: All selectors share one code table
// R11: Each sequencer follows its own selector
// R12: Raw flag set on flagged step completion
// R13: Gate off hides flag from interrupt line
// R14: Zero writes and reserved bits no effect
module asq_ctrl
(
    input  wire logic                                  core_clk,
    input  wire logic                                  rst,
    input  wire logic [asq_pkg::ADDR_W-1:0]            s_axi_awaddr,
    input  wire logic                                  s_axi_awvalid,
    output logic                                       s_axi_awready,
    input  wire logic [31:0]                           s_axi_wdata,
    input  wire logic [3:0]                            s_axi_wstrb,
    input  wire logic                                  s_axi_wvalid,
    output logic                                       s_axi_wready,
    output logic [1:0]                                 s_axi_bresp,
    output logic                                       s_axi_bvalid,
    input  wire logic                                  s_axi_bready,
    input  wire logic [asq_pkg::ADDR_W-1:0]            s_axi_araddr,
    input  wire logic                                  s_axi_arvalid,
    output logic                                       s_axi_arready,
    output logic [31:0]                                s_axi_rdata,
    output logic [1:0]                                 s_axi_rresp,
    output logic                                       s_axi_rvalid,
    input  wire logic                                  s_axi_rready,
    input  wire logic [asq_pkg::NUM_SEQ-1:0]           sample_done,
    input  wire logic [asq_pkg::NUM_SEQ-1:0]           step_irq_request,
    input  wire logic [asq_pkg::NUM_SEQ*asq_pkg::SAMPLE_W-1:0] sample_data,
    input  wire logic [asq_pkg::NUM_SEQ-1:0]           fifo_pop,
    input  wire logic [asq_pkg::NUM_SEQ-1:0]           trig_comp0,
    input  wire logic [asq_pkg::NUM_SEQ-1:0]           trig_pin,
    input  wire logic [asq_pkg::NUM_SEQ-1:0]           trig_timer,
    input  wire logic [asq_pkg::NUM_SEQ-1:0]           trig_pwm0,
    input  wire logic [asq_pkg::NUM_SEQ-1:0]           trig_pwm1,
    input  wire logic [asq_pkg::NUM_SEQ-1:0]           trig_proc,
    output logic [asq_pkg::NUM_SEQ-1:0]                seq_start,
    output logic [asq_pkg::NUM_SEQ-1:0]                seq_irq,
    output logic                                       irq,
    output logic [asq_pkg::NUM_SEQ*asq_pkg::SAMPLE_W-1:0] fifo_head,
    output logic [asq_pkg::NUM_SEQ-1:0]                fifo_full,
    output logic [asq_pkg::NUM_SEQ-1:0]                fifo_empty
);
    import asq_pkg::*;

    typedef logic [PTR_W:0] asq_cnt_t;
    typedef struct packed {
        asq_bus_e              wst;
        asq_bus_e              rst_st;
        logic [ADDR_W-1:0]     awaddr;
        logic                  aw_got;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  w_got;
        logic [1:0]            bresp;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [NUM_SEQ-1:0]    raw_seq_flag;
        logic [NUM_SEQ-1:0]    irq_gate_reg;
        logic [NUM_SEQ-1:0]    fifo_full_drop_flag;
        logic [NUM_SEQ*SEL_W-1:0] trigger_code_field;
        logic [NUM_SEQ-1:0]    seq_irq;
        logic                  irq;
        logic [NUM_SEQ-1:0]    full;
        logic [NUM_SEQ-1:0]    empty;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic                  arready;
        logic                  rvalid;
    } asq_ctrl_s;

    asq_ctrl_s st;
    asq_ctrl_s next_st;

    asq_cnt_t [NUM_SEQ-1:0]    fcnt;
    asq_cnt_t [NUM_SEQ-1:0]    next_fcnt;
    logic [PTR_W-1:0]          wptr [NUM_SEQ];
    logic [PTR_W-1:0]          rptr [NUM_SEQ];
    logic [PTR_W-1:0]          next_wptr [NUM_SEQ];
    logic [PTR_W-1:0]          next_rptr [NUM_SEQ];
    logic [NUM_SEQ-1:0]        push_ok;
    logic [NUM_SEQ-1:0]        pop_ok;
    logic [NUM_SEQ-1:0]        starts;

    // -------------------------------------------------
    // Per-sequencer trigger selectors and result FIFOs
    // -------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_SEQ; g++)
        begin : gen_seq
            asq_trig_if ti ();
            assign ti.code    = st.trigger_code_field[g*SEL_W +: SEL_W]; // R11
            assign ti.comp0   = trig_comp0[g];
            assign ti.pin     = trig_pin[g];
            assign ti.timer   = trig_timer[g];
            assign ti.pwm0    = trig_pwm0[g];
            assign ti.pwm1    = trig_pwm1[g];
            assign ti.proc_go = trig_proc[g];
            assign starts[g]  = ti.start;
            asq_trig_sel u_sel (
                .core_clk (core_clk),
                .rst      (rst),
                .t        (ti)
            );
            // Full sample discarded here, memory and pointers untouched
            assign push_ok[g] = sample_done[g] && !st.full[g]; // R6
            assign pop_ok[g]  = fifo_pop[g] && !st.empty[g];
            asq_mem #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH), .AW(PTR_W)) u_mem (
                .core_clk (core_clk),
                .we       (push_ok[g]),
                .waddr    (wptr[g]),
                .wdata    (sample_data[g*SAMPLE_W +: SAMPLE_W]),
                .raddr    (next_rptr[g]),
                .rdata    (fifo_head[g*SAMPLE_W +: SAMPLE_W])
            );
        end
    endgenerate

    always_comb
    begin
        for (int i = 0; i < NUM_SEQ; i++)
        begin
            next_wptr[i] = push_ok[i] ? PTR_W'(wptr[i] + 1'b1) : wptr[i]; // R6
            next_rptr[i] = pop_ok[i] ? PTR_W'(rptr[i] + 1'b1) : rptr[i];
            next_fcnt[i] = fcnt[i];
            if (push_ok[i] && !pop_ok[i])
                next_fcnt[i] = asq_cnt_t'(fcnt[i] + 1'b1);
            else if (pop_ok[i] && !push_ok[i])
                next_fcnt[i] = asq_cnt_t'(fcnt[i] - 1'b1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < NUM_SEQ; i++)
        begin
            if (rst)
            begin
                wptr[i] <= '0;
                rptr[i] <= '0;
                fcnt[i] <= '0;
            end
            else
            begin
                wptr[i] <= next_wptr[i];
                rptr[i] <= next_rptr[i];
                fcnt[i] <= next_fcnt[i];
            end
        end
    end

    // -------------------------------------------------
    // Register bus and flag logic
    // -------------------------------------------------
    logic                 wr_fire;
    logic                 rd_fire;
    logic [NUM_SEQ-1:0]   clr_irq;
    logic [NUM_SEQ-1:0]   clr_ovf;
    logic [NUM_SEQ-1:0]   gated;
    logic [31:0]          rd_val;
    logic                 rd_hit;
    logic                 wr_hit;

    always_comb
    begin
        next_st = st;
        gated   = st.raw_seq_flag & st.irq_gate_reg;
        wr_fire = st.aw_got && st.w_got && (st.wst == ASQ_IDLE);
        rd_fire = s_axi_arvalid && (st.rst_st == ASQ_IDLE);
        clr_irq = '0;
        clr_ovf = '0;
        wr_hit  = 1'b0;
        rd_hit  = 1'b0;
        rd_val  = RD_ZERO;

        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end

        if (wr_fire)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.wst    = ASQ_RESP;
            // Only the low byte lane carries live bits, the low two lanes for trigger select; upper bits are reserved
            case (st.awaddr)
                OFF_RAW_STATUS: wr_hit = 1'b1;
                OFF_IRQ_GATE:
                begin
                    wr_hit = 1'b1;
                    if (st.wstrb[0])
                        next_st.irq_gate_reg = st.wdata[NUM_SEQ-1:0];
                end
                OFF_IRQ_STATUS:
                begin
                    wr_hit = 1'b1;
                    if (st.wstrb[0])
                        clr_irq = st.wdata[NUM_SEQ-1:0]; // R2 R3 R14
                end
                OFF_FIFO_FULL:
                begin
                    wr_hit = 1'b1;
                    if (st.wstrb[0])
                        clr_ovf = st.wdata[NUM_SEQ-1:0]; // R7 R14
                end
                OFF_TRIG_SEL:
                begin
                    wr_hit = 1'b1;
                    if (st.wstrb[0])
                        next_st.trigger_code_field[7:0] = st.wdata[7:0]; // R8
                    if (st.wstrb[1])
                        next_st.trigger_code_field[15:8] = st.wdata[15:8]; // R8
                end
                default: wr_hit = 1'b0;
            endcase
            next_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (st.wst == ASQ_RESP && s_axi_bready)
            next_st.wst = ASQ_IDLE;

        if (rd_fire)
        begin
            case (s_axi_araddr)
                OFF_RAW_STATUS: begin rd_hit = 1'b1; rd_val[NUM_SEQ-1:0] = st.raw_seq_flag; end
                OFF_IRQ_GATE:   begin rd_hit = 1'b1; rd_val[NUM_SEQ-1:0] = st.irq_gate_reg; end
                OFF_IRQ_STATUS: begin rd_hit = 1'b1; rd_val[NUM_SEQ-1:0] = gated; end // R1
                OFF_FIFO_FULL:  begin rd_hit = 1'b1; rd_val[NUM_SEQ-1:0] = st.fifo_full_drop_flag; end
                OFF_TRIG_SEL:   begin rd_hit = 1'b1; rd_val[15:0] = st.trigger_code_field; end // R8
                default:        rd_hit = 1'b0;
            endcase
            next_st.rdata  = rd_val;
            next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
            next_st.rst_st = ASQ_RESP;
        end
        else if (st.rst_st == ASQ_RESP && s_axi_rready)
            next_st.rst_st = ASQ_IDLE;

        // Set beats clear so an event in the clearing cycle survives
        next_st.raw_seq_flag = (st.raw_seq_flag & ~clr_irq)
                             | (sample_done & step_irq_request); // R12 R2
        next_st.fifo_full_drop_flag = (st.fifo_full_drop_flag & ~clr_ovf)
                                    | (sample_done & st.full); // R5 R7

        for (int i = 0; i < NUM_SEQ; i++)
        begin
            next_st.full[i]  = (next_fcnt[i] == asq_cnt_t'(FIFO_DEPTH));
            next_st.empty[i] = (next_fcnt[i] == '0);
        end

        // One line per sequencer plus a combined line, all level style
        next_st.seq_irq = next_st.raw_seq_flag & next_st.irq_gate_reg; // R4 R13
        next_st.irq     = |next_st.seq_irq; // R4

        // Handshake outputs registered; no new write is taken while a response waits
        next_st.awready = !next_st.aw_got && (next_st.wst == ASQ_IDLE);
        next_st.wready  = !next_st.w_got && (next_st.wst == ASQ_IDLE);
        next_st.bvalid  = (next_st.wst == ASQ_RESP);
        next_st.arready = (next_st.rst_st == ASQ_IDLE);
        next_st.rvalid  = (next_st.rst_st == ASQ_RESP);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st                    <= '0;
            st.empty              <= '1;
            st.awready            <= 1'b1;
            st.wready             <= 1'b1;
            st.arready            <= 1'b1;
            st.trigger_code_field <= TRIG_RESET; // R9
        end
        else
            st <= next_st;
    end

    // -------------------------------------------------
    // Outputs
    // -------------------------------------------------
    logic [NUM_SEQ-1:0] start_q;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            start_q <= '0;
        else
            start_q <= starts; // R11
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign seq_irq       = st.seq_irq;
    assign irq           = st.irq;
    assign fifo_full     = st.full;
    assign fifo_empty    = st.empty;
    assign seq_start     = start_q;
endmodule
`default_nettype wire

//--- rtl/asq_mem.sv
`timescale 1ns/1ps
`default_nettype none
module asq_mem
#(
    parameter int W     = 12,
    parameter int DEPTH = 8,
    parameter int AW    = 3
)
(
    input  wire logic          core_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic [W-1:0]       rdata
);
    logic [W-1:0] mem [DEPTH];
    // Registered read keeps the head word glitch free
    always_ff @(posedge core_clk)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
    end
endmodule
`default_nettype wire

//--- tb/asq_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module asq_ctrl_properties
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  sample_done,
    input  wire logic [3:0]  fifo_pop,
    input  wire logic [3:0]  seq_irq,
    input  wire logic        irq,
    input  wire logic [47:0] fifo_head,
    input  wire logic [3:0]  fifo_full,
    input  wire logic [3:0]  fifo_empty
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_irq_or;
        irq == (seq_irq != 4'h0);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq is not the OR of seq_irq");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer changed early");
    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_refuse;
        s_axi_bvalid |-> !s_axi_awready;
    endproperty
    a_refuse: assert property (p_refuse) else $error("write address taken before response");
    // A full FIFO must not move on a dropped sample
    property p_drop;
        sample_done[3] && fifo_full[3] && !fifo_pop[3] |=> fifo_full[3] && $stable(fifo_head[47:36]);
    endproperty
    a_drop: assert property (p_drop) else $error("overflow sample changed the FIFO");
    property p_push;
        sample_done[3] && !fifo_full[3] |=> !fifo_empty[3];
    endproperty
    a_push: assert property (p_push) else $error("accepted sample left FIFO empty");
    property p_excl;
        (fifo_full & fifo_empty) == 4'h0;
    endproperty
    a_excl: assert property (p_excl) else $error("FIFO full and empty at once");
endmodule
bind asq_ctrl asq_ctrl_properties u_props (.core_clk(core_clk), .rst(rst), .s_axi_awready(s_axi_awready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .sample_done(sample_done), .fifo_pop(fifo_pop), .seq_irq(seq_irq),
    .irq(irq), .fifo_head(fifo_head), .fifo_full(fifo_full), .fifo_empty(fifo_empty));
`default_nettype wire

//--- tb/asq_intc_model.sv
`timescale 1ns/1ps
`default_nettype none
module asq_intc_model
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       irq,
    output logic [7:0]      rises
);
    // ----------------------------------------
    // Level interrupt sink
    // ----------------------------------------
    // Counts rising levels only, so a line that toggles while it should stay up shows as extra rises
    logic last;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            last  <= 1'b0;
            rises <= 8'h00;
        end
        else
        begin
            last <= irq;
            if (irq && !last)
                rises <= rises + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- tb/test_adc_seq_irq_overflow_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_seq_irq_overflow_trigger;
    import asq_pkg::*;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] aw_a = '0, ar_a = '0;
    logic [31:0] w_d = '0, d;
    logic        aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0, b_r = 1'b1, r_r = 1'b1;
    logic        awr, wrd, bv, arr, rv, irq;
    logic [1:0]  br, rr;
    logic [3:0]  done = '0, req = '0, pop = '0, start, sirq, full, empty;
    logic [3:0]  tin [6] = '{default: '0};
    logic [47:0] sdat = '0, head;
    logic [7:0]  rises;
    logic [3:0]  codes [8] = '{TRIG_PROC, TRIG_COMP0, TRIG_PIN, TRIG_TIMER, TRIG_PWM0, TRIG_PWM1, TRIG_ALWAYS, 4'h2};
    int          tsel [8] = '{5, 0, 1, 2, 3, 4, 5, 5};
    int          n_fail = 0, n_compared = 0, cyc = 0;
    asq_ctrl DUT (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(awr),
        .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(arr),
        .s_axi_rdata(d), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(r_r), .sample_done(done),
        .step_irq_request(req), .sample_data(sdat), .fifo_pop(pop), .trig_comp0(tin[0]), .trig_pin(tin[1]),
        .trig_timer(tin[2]), .trig_pwm0(tin[3]), .trig_pwm1(tin[4]), .trig_proc(tin[5]), .seq_start(start),
        .seq_irq(sirq), .irq(irq), .fifo_head(head), .fifo_full(full), .fifo_empty(empty));
    asq_intc_model u_intc (.core_clk(core_clk), .rst(rst), .irq(irq), .rises(rises));
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic give_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic [3:0] e, input logic [3:0] g);
        chk_word(nm, {28'h0, e}, {28'h0, g});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Address and data go up together; each drops on its own handshake
    // A nonzero hold keeps bready low for that many cycles of a waiting response
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input int hold = 0);
        aw_a <= a;
        w_d  <= v;
        aw_v <= 1'b1;
        w_v  <= 1'b1;
        b_r  <= (hold == 0);
        do
        begin
            @(posedge core_clk);
            if (aw_v && awr)
                aw_v <= 1'b0;
            if (w_v && wrd)
                w_v <= 1'b0;
            if (bv === 1'b1 && !b_r)
            begin
                hold--;
                b_r <= (hold <= 0);
            end
        end while (!(bv === 1'b1 && b_r));
        chk_word("bresp", {30'h0, RESP_OKAY}, {30'h0, br});
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er, input int hold = 0);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r  <= (hold == 0);
        do
        begin
            @(posedge core_clk);
            if (ar_v && arr)
                ar_v <= 1'b0;
            if (rv === 1'b1 && !r_r)
            begin
                hold--;
                r_r <= (hold <= 0);
            end
        end while (!(rv === 1'b1 && r_r));
        chk_word($sformatf("rdata %h", a), e, d);
        chk_word("rresp", {30'h0, er}, {30'h0, rr});
    endtask
    task automatic trg(input int k, input logic [3:0] e);
        logic [3:0] acc;
        acc = 4'h0;
        tin[k] <= 4'hf;
        @(posedge core_clk);
        tin[k] <= 4'h0;
        repeat (4)
        begin
            @(posedge core_clk);
            acc = acc | start;
        end
        chk_pin("seq_start", e, acc);
    endtask
    task automatic smp(input logic [3:0] m, input logic [11:0] v);
        done <= m;
        sdat <= {4{v}};
        @(posedge core_clk);
        done <= 4'h0;
        @(posedge core_clk);
    endtask
    initial
    begin
        tick(4);
        rst <= 1'b0;
        @(posedge core_clk);
        chk_pin("fifo_empty", 4'hf, empty);
        rdc(OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
        rdc(OFF_FIFO_FULL, 32'h0, RESP_OKAY);
        rdc(OFF_TRIG_SEL, {16'h0, TRIG_RESET}, RESP_OKAY);
        rdc(12'h020, RD_ZERO, RESP_SLVERR);
        for (int i = 0; i < 8; i++)
        begin
            wr(OFF_TRIG_SEL, {16'h0, {4{codes[i]}}});
            tick(4);
            trg(tsel[i], (i < 7) ? 4'hf : 4'h0);
        end
        wr(OFF_TRIG_SEL, 32'hffff_7654);
        rdc(OFF_TRIG_SEL, 32'h0000_7654, RESP_OKAY, 2);
        tick(4);
        trg(2, 4'h2);
        trg(4, 4'h8);
        wr(OFF_IRQ_GATE, 32'h1, 2);
        req <= 4'h3;
        smp(4'h7, 12'h000);
        rdc(OFF_RAW_STATUS, 32'h3, RESP_OKAY);
        rdc(OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
        chk_pin("seq_irq", 4'h1, sirq);
        wr(OFF_IRQ_STATUS, 32'hffff_fff0);
        rdc(OFF_RAW_STATUS, 32'h3, RESP_OKAY);
        wr(OFF_IRQ_STATUS, 32'h2);
        rdc(OFF_RAW_STATUS, 32'h1, RESP_OKAY);
        chk_pin("irq", 4'h1, {3'h0, irq});
        wr(OFF_IRQ_STATUS, 32'h1);
        rdc(OFF_RAW_STATUS, 32'h0, RESP_OKAY);
        chk_pin("irq", 4'h0, {3'h0, irq});
        chk_pin("irq rises", 4'h1, rises[3:0]);
        req <= 4'h0;
        for (int i = 0; i < 8; i++)
            smp(4'h8, 12'(i));
        chk_pin("fifo_full", 4'h8, full);
        smp(4'h8, 12'h0ff);
        rdc(OFF_FIFO_FULL, 32'h8, RESP_OKAY);
        wr(OFF_FIFO_FULL, 32'h7);
        rdc(OFF_FIFO_FULL, 32'h8, RESP_OKAY);
        for (int i = 0; i < 8; i++)
        begin
            chk_word("fifo_head", i, {20'h0, head[47:36]});
            pop <= 4'h8;
            @(posedge core_clk);
            pop <= 4'h0;
            tick(3);
        end
        chk_pin("fifo_empty", 4'h8, empty);
        wr(OFF_FIFO_FULL, 32'h8);
        rdc(OFF_FIFO_FULL, 32'h0, RESP_OKAY);
        give_verdict();
    end
endmodule
`default_nettype wire
